// >>> t0cf_pkg.sv
// Register map, field positions, reset values and codes of the timer/counter
package t0cf_pkg;
  // I/O addresses
  localparam logic [5:0] ADDR_COMPARE_B  = 6'h12;
  localparam logic [5:0] ADDR_COMPARE_A  = 6'h13;
  localparam logic [5:0] ADDR_COUNT_HIGH = 6'h14;
  localparam logic [5:0] ADDR_CONTROL_A  = 6'h15;
  localparam logic [5:0] ADDR_COUNT_LOW  = 6'h32;
  localparam logic [5:0] ADDR_CONTROL_B  = 6'h33;
  localparam logic [5:0] ADDR_FLAGS      = 6'h38;
  localparam logic [5:0] ADDR_MASK       = 6'h39;

  // Control A fields
  localparam int CA_WIDE_BIT    = 7;
  localparam int CA_CAPTURE_BIT = 6;
  // Control B fields
  localparam int CB_SYNC_HOLD_BIT   = 4;
  localparam int CB_PRESC_CLEAR_BIT = 3;
  localparam int CB_CS_MSB          = 2;
  // Flag and mask bit positions (shared layout)
  localparam int BIT_COMPARE_A = 4;
  localparam int BIT_COMPARE_B = 3;
  localparam int BIT_OVERFLOW  = 1;
  localparam int BIT_CAPTURE   = 0;

  // Reset values
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler taps, as log2 of the division ratio
  localparam int DIV8_BITS    = 3;
  localparam int DIV64_BITS   = 6;
  localparam int DIV256_BITS  = 8;
  localparam int DIV1024_BITS = 10;
  localparam int PRESC_WIDTH  = 10;
endpackage

// >>> t0cf_timer.sv
// Timer/counter 0: prescaler, 8/16-bit counter, compare, flags and interrupt requests
//
// Summary of operation
// - Sync hold keeps prescaler clear bit as written
// - Clearing sync hold clears prescaler clear bit
// - Prescaler clear bit self-clears unless sync hold
// - Clock select: stop, div 1/8/64/256/1024
// - Codes 110/111 count external falling/rising edges
// - External pin counts even when driven as output
// - Low count write blocks next compare match
// - Wide mode: one 16-bit counter via shared latch
// - Compare A matches counter low byte
// - Compare B: low byte, or high of 16-bit
// - Request needs enable, global enable and flag
// - Capture request needs enable, global, capture flag
// - Compare A flag: set on match, cleared twice
// - Wide compare sets flag A, not in capture
// - Compare B flag: set on match, cleared twice
// - Compare B flag never set in wide mode
// - Overflow flag set on wrap, cleared twice
// - Wide bit merges counter and compare registers
// - Write high byte first, read low first; low access moves latch
// - Capture flag cleared by vector or one-write
module t0cf_timer #(
  parameter int PRESC_W = t0cf_pkg::PRESC_WIDTH
) (
  input  wire logic       clock_in,         // I/O clock
  input  wire logic       rst_in,           // Synchronous reset, active high
  input  wire logic [5:0] io_addr_in,       // I/O register address
  input  wire logic       io_wr_in,         // Write strobe
  input  wire logic       io_rd_in,         // Read strobe
  input  wire logic [7:0] io_wdata_in,      // Write data
  output logic      [7:0] io_rdata_out,     // Read data, one cycle after strobe
  input  wire logic       global_irq_en_in, // Global interrupt enable
  input  wire logic       ack_compare_a_in, // Compare A vector taken
  input  wire logic       ack_compare_b_in, // Compare B vector taken
  input  wire logic       ack_overflow_in,  // Overflow vector taken
  input  wire logic       ack_capture_in,   // Capture vector taken
  input  wire logic       capture_event_in, // Capture event from front end
  input  wire logic       external_count_pin_in, // External count pin level
  output logic            irq_compare_a_out, // Compare A request
  output logic            irq_compare_b_out, // Compare B request
  output logic            irq_overflow_out,  // Overflow request
  output logic            irq_capture_out    // Capture request
);

  if (PRESC_W < t0cf_pkg::DIV1024_BITS) begin : g_check
    $error("PRESC_W too small for the largest division");
  end

  // Single clock domain; a reset aborts every check in flight
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // All ones in the low n bits of the prescaler
  function automatic logic presc_tap(input logic [PRESC_W-1:0] p, input int n);
    logic ones;
    ones = 1'b1;
    for (int i = 0; i < n; i++) begin
      ones = ones & p[i];
    end
    return ones;
  endfunction

  logic [7:0]         temp_r;
  logic [15:0]        count_r;
  logic [7:0]         cmp_a_r;
  logic [7:0]         cmp_b_r;
  logic               wide_r;
  logic               capture_mode_r;
  logic               sync_hold_r;
  logic               psr_r;
  logic [2:0]         cs_r;
  logic [PRESC_W-1:0] presc_r;
  logic               ext_s1_r;
  logic               ext_s2_r;
  logic               ext_d3_r;
  logic               cmp_block_r;
  logic               flag_a_r;
  logic               flag_b_r;
  logic               flag_ovf_r;
  logic               flag_cap_r;
  logic               en_a_r;
  logic               en_b_r;
  logic               en_ovf_r;
  logic               en_cap_r;

  // Address decode
  wire wr_ctrl_a = io_wr_in && io_addr_in == t0cf_pkg::ADDR_CONTROL_A;
  wire wr_ctrl_b = io_wr_in && io_addr_in == t0cf_pkg::ADDR_CONTROL_B;
  wire wr_low    = io_wr_in && io_addr_in == t0cf_pkg::ADDR_COUNT_LOW;
  wire wr_high   = io_wr_in && io_addr_in == t0cf_pkg::ADDR_COUNT_HIGH;
  wire wr_cmp_a  = io_wr_in && io_addr_in == t0cf_pkg::ADDR_COMPARE_A;
  wire wr_cmp_b  = io_wr_in && io_addr_in == t0cf_pkg::ADDR_COMPARE_B;
  wire wr_flags  = io_wr_in && io_addr_in == t0cf_pkg::ADDR_FLAGS;
  wire wr_mask   = io_wr_in && io_addr_in == t0cf_pkg::ADDR_MASK;
  wire rd_low    = io_rd_in && io_addr_in == t0cf_pkg::ADDR_COUNT_LOW;
  wire rd_cmp_a  = io_rd_in && io_addr_in == t0cf_pkg::ADDR_COMPARE_A;

  // Tick selection; a held prescaler clear also halts the undivided source
  wire ext_rise = ext_s2_r && !ext_d3_r;
  wire ext_fall = !ext_s2_r && ext_d3_r;
  logic tick_src;
  always_comb begin
    unique case (cs_r)
      t0cf_pkg::CS_STOP:     tick_src = 1'b0;
      t0cf_pkg::CS_DIV1:     tick_src = 1'b1;
      t0cf_pkg::CS_DIV8:     tick_src = presc_tap(presc_r, t0cf_pkg::DIV8_BITS);
      t0cf_pkg::CS_DIV64:    tick_src = presc_tap(presc_r, t0cf_pkg::DIV64_BITS);
      t0cf_pkg::CS_DIV256:   tick_src = presc_tap(presc_r, t0cf_pkg::DIV256_BITS);
      t0cf_pkg::CS_DIV1024:  tick_src = presc_tap(presc_r, t0cf_pkg::DIV1024_BITS);
      t0cf_pkg::CS_EXT_FALL: tick_src = ext_fall;
      t0cf_pkg::CS_EXT_RISE: tick_src = ext_rise;
    endcase
  end
  wire timer_tick = tick_src && !psr_r;

  // Counter next value and overflow
  wire [15:0] count_inc = count_r + 16'h0001;
  wire        wrap_lo   = count_r[7:0] == 8'hFF;
  wire        wrap_all  = count_r == 16'hFFFF;
  wire        overflow  = timer_tick && (wide_r ? wrap_all : wrap_lo);
  wire        cnt_write = wr_low || wr_high;

  // Compare decode
  wire match_a8  = count_r[7:0] == cmp_a_r;
  wire match_b8  = count_r[7:0] == cmp_b_r;
  wire match_16  = count_r == {cmp_b_r, cmp_a_r};
  wire cmp_ok    = timer_tick && !cmp_block_r && !capture_mode_r;
  wire set_a     = cmp_ok && (wide_r ? match_16 : match_a8);
  wire set_b     = cmp_ok && !wide_r && match_b8;
  wire set_cap   = capture_event_in && capture_mode_r;

  // Flag next values: a set in the clearing cycle wins
  wire [7:0] fclr = wr_flags ? io_wdata_in : 8'h00;
  wire flag_a_nxt   = set_a || (flag_a_r && !fclr[t0cf_pkg::BIT_COMPARE_A]
                      && !ack_compare_a_in);
  wire flag_b_nxt   = set_b || (flag_b_r && !fclr[t0cf_pkg::BIT_COMPARE_B]
                      && !ack_compare_b_in);
  wire flag_ovf_nxt = overflow || (flag_ovf_r && !fclr[t0cf_pkg::BIT_OVERFLOW]
                      && !ack_overflow_in);
  wire flag_cap_nxt = set_cap || (flag_cap_r && !fclr[t0cf_pkg::BIT_CAPTURE]
                      && !ack_capture_in);

  // Capture mode blocks compare A sets; clears act only when no set falls in the same cycle
  a_cap_blocks_a: assert property (
    capture_mode_r && !flag_a_r |=> !flag_a_r)
    else $error("compare A flag set in capture mode");
  a_b_sw_clear: assert property (
    flag_b_r && fclr[t0cf_pkg::BIT_COMPARE_B] && !set_b |=> !flag_b_r)
    else $error("compare B flag ignored its write-one clear");
  a_ovf_ack_clear: assert property (
    flag_ovf_r && ack_overflow_in && !overflow |=> !flag_ovf_r)
    else $error("overflow flag ignored its vector");
  a_cap_ack_clear: assert property (
    flag_cap_r && ack_capture_in && !set_cap |=> !flag_cap_r)
    else $error("capture flag ignored its vector");

  // Read mux; in wide mode the count high byte, and compare B in capture mode, come from the shared latch
  wire [7:0] flags_rd = {3'h0, flag_a_r, flag_b_r, 1'b0, flag_ovf_r, flag_cap_r};
  wire [7:0] mask_rd  = {3'h0, en_a_r, en_b_r, 1'b0, en_ovf_r, en_cap_r};
  wire [7:0] ctrl_a_rd = {wide_r, capture_mode_r, 6'h00};
  wire [7:0] ctrl_b_rd = {3'h0, sync_hold_r, psr_r, cs_r};
  logic [7:0] rdata_nxt;
  always_comb begin
    unique case (io_addr_in)
      t0cf_pkg::ADDR_COUNT_LOW:  rdata_nxt = count_r[7:0];
      t0cf_pkg::ADDR_COUNT_HIGH: rdata_nxt = wide_r ? temp_r : count_r[15:8];
      t0cf_pkg::ADDR_COMPARE_A:  rdata_nxt = cmp_a_r;
      t0cf_pkg::ADDR_COMPARE_B:  rdata_nxt = (wide_r && capture_mode_r) ? temp_r : cmp_b_r;
      t0cf_pkg::ADDR_CONTROL_A:  rdata_nxt = ctrl_a_rd;
      t0cf_pkg::ADDR_CONTROL_B:  rdata_nxt = ctrl_b_rd;
      t0cf_pkg::ADDR_FLAGS:      rdata_nxt = flags_rd;
      t0cf_pkg::ADDR_MASK:       rdata_nxt = mask_rd;
      default:                   rdata_nxt = t0cf_pkg::RESET_BYTE;
    endcase
  end

  // External pin synchroniser and edge history
  always_ff @(posedge clock_in) begin
    ext_s1_r <= external_count_pin_in;
    ext_s2_r <= ext_s1_r;
    ext_d3_r <= ext_s2_r;
  end

  // Control registers and prescaler
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wide_r         <= 1'b0;
      capture_mode_r <= 1'b0;
      sync_hold_r    <= 1'b0;
      psr_r          <= 1'b0;
      cs_r           <= t0cf_pkg::CS_STOP;
      presc_r        <= '0;
    end else begin
      if (wr_ctrl_a) begin
        wide_r         <= io_wdata_in[t0cf_pkg::CA_WIDE_BIT];
        capture_mode_r <= io_wdata_in[t0cf_pkg::CA_CAPTURE_BIT];
      end
      if (wr_ctrl_b) begin
        sync_hold_r <= io_wdata_in[t0cf_pkg::CB_SYNC_HOLD_BIT];
        psr_r       <= io_wdata_in[t0cf_pkg::CB_PRESC_CLEAR_BIT];
        cs_r        <= io_wdata_in[t0cf_pkg::CB_CS_MSB:0];
      end else if (!sync_hold_r) begin
        psr_r <= 1'b0;
      end
      presc_r <= psr_r ? '0 : presc_r + 1'b1;
    end
  end

  a_presc_cleared: assert property (psr_r |=> presc_r == '0)
    else $error("prescaler not held clear by its clear bit");

  // Counter, shared latch and compare registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_r     <= t0cf_pkg::RESET_WORD;
      temp_r      <= t0cf_pkg::RESET_BYTE;
      cmp_a_r     <= t0cf_pkg::RESET_BYTE;
      cmp_b_r     <= t0cf_pkg::RESET_BYTE;
      cmp_block_r <= 1'b0;
    end else begin
      if (wr_low && wide_r) begin
        count_r <= {temp_r, io_wdata_in};
      end else if (wr_low) begin
        count_r[7:0] <= io_wdata_in;
      end else if (wr_high && !wide_r) begin
        count_r[15:8] <= io_wdata_in;
      end else if (timer_tick && wide_r) begin
        count_r <= count_inc;
      end else if (timer_tick) begin
        count_r[7:0] <= count_inc[7:0];
      end
      // Latch loads; a capture snapshot overrides software this cycle
      if ((wr_high || wr_cmp_b) && wide_r) begin
        temp_r <= io_wdata_in;
      end else if (rd_low && wide_r) begin
        temp_r <= count_r[15:8];
      end else if (rd_cmp_a && wide_r && capture_mode_r) begin
        temp_r <= cmp_b_r;
      end
      if (set_cap) begin
        cmp_a_r <= count_r[7:0];
        cmp_b_r <= count_r[15:8];
      end else if (wr_cmp_a && wide_r) begin
        cmp_a_r <= io_wdata_in;
        cmp_b_r <= temp_r;
      end else if (wr_cmp_a) begin
        cmp_a_r <= io_wdata_in;
      end else if (wr_cmp_b && !wide_r) begin
        cmp_b_r <= io_wdata_in;
      end
      if (wr_low) begin
        cmp_block_r <= 1'b1;
      end else if (timer_tick) begin
        cmp_block_r <= 1'b0;
      end
    end
  end

  a_wide_carry: assert property (
    wide_r && timer_tick && !cnt_write |=> count_r == $past(count_r) + 16'h0001)
    else $error("16-bit count did not carry into the high byte");
  a_low_read_latch: assert property (
    rd_low && wide_r && !wr_high && !wr_cmp_b |=> temp_r == $past(count_r[15:8]))
    else $error("low byte read did not latch the high byte");

  // Flags, enables, requests and read data
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      flag_a_r          <= 1'b0;
      flag_b_r          <= 1'b0;
      flag_ovf_r        <= 1'b0;
      flag_cap_r        <= 1'b0;
      en_a_r            <= 1'b0;
      en_b_r            <= 1'b0;
      en_ovf_r          <= 1'b0;
      en_cap_r          <= 1'b0;
      irq_compare_a_out <= 1'b0;
      irq_compare_b_out <= 1'b0;
      irq_overflow_out  <= 1'b0;
      irq_capture_out   <= 1'b0;
      io_rdata_out      <= t0cf_pkg::RESET_BYTE;
    end else begin
      flag_a_r   <= flag_a_nxt;
      flag_b_r   <= flag_b_nxt;
      flag_ovf_r <= flag_ovf_nxt;
      flag_cap_r <= flag_cap_nxt;
      if (wr_mask) begin
        en_a_r   <= io_wdata_in[t0cf_pkg::BIT_COMPARE_A];
        en_b_r   <= io_wdata_in[t0cf_pkg::BIT_COMPARE_B];
        en_ovf_r <= io_wdata_in[t0cf_pkg::BIT_OVERFLOW];
        en_cap_r <= io_wdata_in[t0cf_pkg::BIT_CAPTURE];
      end
      irq_compare_a_out <= en_a_r && global_irq_en_in && flag_a_r;
      irq_compare_b_out <= en_b_r && global_irq_en_in && flag_b_r;
      irq_overflow_out  <= en_ovf_r && global_irq_en_in && flag_ovf_r;
      irq_capture_out   <= en_cap_r && global_irq_en_in && flag_cap_r;
      if (io_rd_in) begin
        io_rdata_out <= rdata_nxt;
      end
    end
  end

  a_psr_self_clear: assert property (psr_r && !sync_hold_r && !wr_ctrl_b |=> !psr_r)
    else $error("prescaler clear bit did not self-clear");
  a_sync_hold_keeps: assert property (psr_r && sync_hold_r && !wr_ctrl_b |=> psr_r)
    else $error("prescaler clear bit lost under sync hold");
  a_hold_release: assert property (
    wr_ctrl_b && !io_wdata_in[t0cf_pkg::CB_SYNC_HOLD_BIT] ##1 !wr_ctrl_b |=> !psr_r)
    else $error("release of sync hold left prescaler in reset");
  a_held_no_count: assert property (psr_r && !cnt_write |=> count_r == $past(count_r))
    else $error("counter advanced while prescaler held");
  a_ext_rise_count: assert property (
    cs_r == t0cf_pkg::CS_EXT_RISE && !psr_r && ext_rise && !cnt_write && !wide_r
    |=> count_r[7:0] == $past(count_r[7:0]) + 8'h01)
    else $error("external rising edge not counted");
  a_ext_fall_count: assert property (
    cs_r == t0cf_pkg::CS_EXT_FALL && !psr_r && ext_fall && !cnt_write && !wide_r
    |=> count_r[7:0] == $past(count_r[7:0]) + 8'h01)
    else $error("external falling edge not counted");
  a_div8_rate: assert property (
    cs_r == t0cf_pkg::CS_DIV8 && timer_tick |-> presc_r[2:0] == 3'h7)
    else $error("divide by 8 tick at wrong prescaler phase");
  a_block_match: assert property (wr_low ##1 (timer_tick && !wr_low) |-> !set_a && !set_b)
    else $error("compare match not blocked after low write");
  a_wide_write: assert property (
    wr_low && wide_r |=> count_r == {$past(temp_r), $past(io_wdata_in)})
    else $error("16-bit write did not load both bytes");
  a_irq_gating: assert property (
    irq_compare_a_out |-> $past(en_a_r && global_irq_en_in && flag_a_r))
    else $error("compare A request without its conditions");
  a_cap_irq_gating: assert property (
    irq_capture_out |-> $past(en_cap_r && global_irq_en_in && flag_cap_r))
    else $error("capture request without its conditions");
  a_flag_set_wins: assert property (set_a |=> flag_a_r)
    else $error("compare A flag set was lost");
  a_b_never_wide: assert property (wide_r && !flag_b_r |=> !flag_b_r)
    else $error("compare B flag set in wide mode");
  a_ovf_flag: assert property (overflow |=> flag_ovf_r)
    else $error("overflow did not set its flag");

endmodule

// >>> test_timer0_control_and_flags.sv
// Self-checking testbench for the timer/counter control and flag logic
module test_timer0_control_and_flags;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [5:0] addr;
    logic       do_wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } t0cf_row_t;

  logic       clock_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [5:0] io_addr_in = 6'h00;
  logic       io_wr_in = 1'b0;
  logic       io_rd_in = 1'b0;
  logic [7:0] io_wdata_in = 8'h00;
  logic [7:0] io_rdata_out;
  logic       global_irq_en_in = 1'b0;
  logic       ack_a = 1'b0;
  logic       ack_b = 1'b0;
  logic       ack_ovf = 1'b0;
  logic       ack_cap = 1'b0;
  logic       capture_event_in = 1'b0;
  logic       ext_pin = 1'b0;
  logic       irq_a, irq_b, irq_ovf, irq_cap;
  int         error_cnt = 0;
  int         check_count = 0;
  int         divs [4] = '{8, 64, 256, 1024};
  int         ticks [4] = '{4, 4, 4, 2};
  logic [7:0] rv;
  t0cf_row_t  rows [16] = '{
    '{6'h14, 1'b0, 8'h00, 8'h00}, '{6'h33, 1'b0, 8'h00, 8'h00},
    '{6'h38, 1'b0, 8'h00, 8'h00}, '{6'h39, 1'b0, 8'h00, 8'h00},
    '{6'h32, 1'b0, 8'h00, 8'h00}, '{6'h13, 1'b0, 8'h00, 8'h00},
    '{6'h12, 1'b0, 8'h00, 8'h00}, '{6'h39, 1'b1, 8'hFF, 8'h1B},
    '{6'h39, 1'b1, 8'h00, 8'h00}, '{6'h33, 1'b1, 8'hE0, 8'h00},
    '{6'h33, 1'b1, 8'h18, 8'h18}, '{6'h33, 1'b1, 8'h00, 8'h00},
    '{6'h33, 1'b1, 8'h08, 8'h00}, '{6'h3F, 1'b1, 8'h55, 8'h00},
    '{6'h13, 1'b1, 8'hA5, 8'hA5}, '{6'h12, 1'b1, 8'h5A, 8'h5A}};

  t0cf_timer dut (
    .clock_in              (clock_in),
    .rst_in                (rst_in),
    .io_addr_in            (io_addr_in),
    .io_wr_in              (io_wr_in),
    .io_rd_in              (io_rd_in),
    .io_wdata_in           (io_wdata_in),
    .io_rdata_out          (io_rdata_out),
    .global_irq_en_in      (global_irq_en_in),
    .ack_compare_a_in      (ack_a),
    .ack_compare_b_in      (ack_b),
    .ack_overflow_in       (ack_ovf),
    .ack_capture_in        (ack_cap),
    .capture_event_in      (capture_event_in),
    .external_count_pin_in (ext_pin),
    .irq_compare_a_out     (irq_a),
    .irq_compare_b_out     (irq_b),
    .irq_overflow_out      (irq_ovf),
    .irq_capture_out       (irq_cap)
  );

  always #5 clock_in = ~clock_in;

  // Every drive lands 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle cycle after each strobe so no signal is driven twice in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    step(1);
    io_wr_in = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    io_addr_in = a;
    io_rd_in = 1'b1;
    step(1);
    io_rd_in = 1'b0;
    d = io_rdata_out;
    step(1);
  endtask

  task automatic irqs(input logic [3:0] exp);
    check({4'h0, irq_a, irq_b, irq_ovf, irq_cap}, {4'h0, exp});
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    step(12);
    rst_in = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].do_wr)
        wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rv);
      check(rv, rows[i].exp);
    end
    // Prescaled counts: counter held by sync hold, then released
    for (int i = 0; i < 4; i++) begin
      wr(t0cf_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(t0cf_pkg::ADDR_CONTROL_B, 8'h18 | (8'h02 + 8'(i)));
      step(40);
      rd(t0cf_pkg::ADDR_COUNT_LOW, rv);
      check(rv, 8'h00);
      wr(t0cf_pkg::ADDR_CONTROL_B, 8'h02 + 8'(i));
      rd(t0cf_pkg::ADDR_CONTROL_B, rv);
      check(rv, 8'h02 + 8'(i));
      step(divs[i] * ticks[i] + divs[i] / 2 - 4);
      wr(t0cf_pkg::ADDR_CONTROL_B, 8'h00);
      rd(t0cf_pkg::ADDR_COUNT_LOW, rv);
      check(rv, 8'(ticks[i]));
    end
    // Undivided clock through wrap and both compare values
    wr(t0cf_pkg::ADDR_COMPARE_A, 8'h05);
    wr(t0cf_pkg::ADDR_COMPARE_B, 8'h08);
    wr(t0cf_pkg::ADDR_COUNT_LOW, 8'hF0);
    wr(t0cf_pkg::ADDR_CONTROL_B, {5'h00, t0cf_pkg::CS_DIV1});
    step(40);
    wr(t0cf_pkg::ADDR_CONTROL_B, 8'h00);
    rd(t0cf_pkg::ADDR_FLAGS, rv);
    check(rv, 8'h1A);
    wr(t0cf_pkg::ADDR_MASK, 8'h1A);
    global_irq_en_in = 1'b1;
    step(3);
    irqs(4'hE);
    global_irq_en_in = 1'b0;
    step(3);
    irqs(4'h0);
    global_irq_en_in = 1'b1;
    ack_a = 1'b1;
    step(1);
    ack_a = 1'b0;
    step(3);
    irqs(4'h6);
    wr(t0cf_pkg::ADDR_FLAGS, 8'h08);
    ack_ovf = 1'b1;
    step(1);
    ack_ovf = 1'b0;
    rd(t0cf_pkg::ADDR_FLAGS, rv);
    check(rv, 8'h00);
    // Low count write hides the match on the following tick
    wr(t0cf_pkg::ADDR_COMPARE_A, 8'h40);
    wr(t0cf_pkg::ADDR_CONTROL_B, {5'h00, t0cf_pkg::CS_DIV1});
    wr(t0cf_pkg::ADDR_COUNT_LOW, 8'h40);
    wr(t0cf_pkg::ADDR_CONTROL_B, 8'h00);
    rd(t0cf_pkg::ADDR_FLAGS, rv);
    check(rv, 8'h00);
    // External pin: three pulses give three counts in either edge mode
    for (int m = 6; m < 8; m++) begin
      wr(t0cf_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(t0cf_pkg::ADDR_CONTROL_B, 8'(m));
      step(4);
      repeat (3) begin
        ext_pin = 1'b1;
        step(4);
        ext_pin = 1'b0;
        step(4);
      end
      step(4);
      wr(t0cf_pkg::ADDR_CONTROL_B, 8'h00);
      rd(t0cf_pkg::ADDR_COUNT_LOW, rv);
      check(rv, 8'h03);
    end
    // Wide mode: 16-bit compare 0x0102, count from 0x00F8
    wr(t0cf_pkg::ADDR_CONTROL_A, 8'h80);
    wr(t0cf_pkg::ADDR_COMPARE_B, 8'h01);
    wr(t0cf_pkg::ADDR_COMPARE_A, 8'h02);
    wr(t0cf_pkg::ADDR_COUNT_HIGH, 8'h00);
    wr(t0cf_pkg::ADDR_COUNT_LOW, 8'hF8);
    wr(t0cf_pkg::ADDR_CONTROL_B, {5'h00, t0cf_pkg::CS_DIV1});
    step(30);
    wr(t0cf_pkg::ADDR_CONTROL_B, 8'h00);
    rd(t0cf_pkg::ADDR_FLAGS, rv);
    check(rv, 8'h10);
    rd(t0cf_pkg::ADDR_COUNT_LOW, rv);
    rd(t0cf_pkg::ADDR_COUNT_HIGH, rv);
    check(rv, 8'h01);
    rd(t0cf_pkg::ADDR_COMPARE_B, rv);
    check(rv, 8'h01);
    // Capture flag, its request and its clear by vector
    wr(t0cf_pkg::ADDR_FLAGS, 8'h1B);
    wr(t0cf_pkg::ADDR_CONTROL_A, 8'hC0);
    wr(t0cf_pkg::ADDR_MASK, 8'h01);
    capture_event_in = 1'b1;
    step(1);
    capture_event_in = 1'b0;
    step(3);
    irqs(4'h1);
    ack_cap = 1'b1;
    step(1);
    ack_cap = 1'b0;
    rd(t0cf_pkg::ADDR_FLAGS, rv);
    check(rv, 8'h00);
    irqs(4'h0);
    // Mid-run reset with a pending capture request
    capture_event_in = 1'b1;
    step(1);
    capture_event_in = 1'b0;
    step(2);
    irqs(4'h1);
    rst_in = 1'b1;
    step(2);
    rst_in = 1'b0;
    irqs(4'h0);
    rd(t0cf_pkg::ADDR_FLAGS, rv);
    check(rv, 8'h00);
    rd(t0cf_pkg::ADDR_CONTROL_A, rv);
    check(rv, 8'h00);
    final_report();
  end
endmodule
